// [src/therm_master.sv]
// Bus master end: issues commands and polls or powers the conversion.
// Assumes the device end is joined through the same link interface.
`timescale 1ns/1ns
`default_nettype none
`include "therm_regs.svh"
module therm_master (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    therm_link_if.master link,
    input wire logic start_in,
    input wire logic parasite_in,
    input wire logic cfg_wr_in,
    input wire logic [7:0] cfg_in,
    output logic busy_out,
    output logic done_out,
    output logic [15:0] temp_out
);
    typedef enum logic [2:0] {M_IDLE, M_CMD, M_POLL, M_SAMPLE, M_POWER, M_DONE} mstate_t;
    mstate_t st_q, st_d;
    logic [31:0] cnt_q, cnt_d;
    logic valid_q, valid_d, slot_q, slot_d, spu_q, spu_d, busy_q, busy_d, done_q, done_d;
    logic [7:0] code_q, code_d, arg_q, arg_d;
    logic [15:0] temp_q, temp_d;
    logic dq_s1_q, dq_s2_q;
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        valid_d = 1'b0;
        slot_d = 1'b0;
        spu_d = spu_q;
        busy_d = busy_q;
        done_d = 1'b0;
        code_d = code_q;
        arg_d = arg_q;
        temp_d = temp_q;
        case (st_q)
            M_IDLE: begin
                busy_d = 1'b0;
                if (cfg_wr_in) begin
                    valid_d = 1'b1;
                    code_d = `CMD_WRITE_CFG;
                    arg_d = cfg_in;
                end else if (start_in) begin
                    valid_d = 1'b1;
                    code_d = `CMD_CONVERT;
                    busy_d = 1'b1;
                    st_d = M_CMD;
                end
            end
            M_CMD: begin
                cnt_d = 32'h0;
                if (parasite_in) begin
                    spu_d = 1'b1;
                    st_d = M_POWER;
                end else begin
                    st_d = M_POLL;
                end
            end
            M_POLL: begin
                slot_d = 1'b1;
                st_d = M_SAMPLE;
            end
            M_SAMPLE: begin
                // Two synchroniser stages plus the slot and device pull stages delay the answer.
                cnt_d = cnt_q + 32'h1;
                if (cnt_q[1:0] == 2'h3) begin
                    cnt_d = 32'h0;
                    st_d = dq_s2_q ? M_DONE : M_POLL;
                end
            end
            M_POWER: begin
                // No read slots while powering the device through the line.
                cnt_d = cnt_q + 32'h1;
                if (cnt_q >= 32'(`CONV_CYCLES + 4)) begin
                    spu_d = 1'b0;
                    st_d = M_DONE;
                end
            end
            default: begin
                temp_d = link.result_word;
                done_d = 1'b1;
                busy_d = 1'b0;
                st_d = M_IDLE;
            end
        endcase
    end
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            st_q <= M_IDLE;
            cnt_q <= 32'h0;
            valid_q <= 1'b0;
            slot_q <= 1'b0;
            spu_q <= 1'b0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            code_q <= 8'h0;
            arg_q <= 8'h0;
            temp_q <= 16'h0;
            dq_s1_q <= 1'b1;
            dq_s2_q <= 1'b1;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            valid_q <= valid_d;
            slot_q <= slot_d;
            spu_q <= spu_d;
            busy_q <= busy_d;
            done_q <= done_d;
            code_q <= code_d;
            arg_q <= arg_d;
            temp_q <= temp_d;
            dq_s1_q <= link.dq_level;
            dq_s2_q <= dq_s1_q;
        end
    end
    // The master never pulls the line itself here; slot framing is elsewhere.
    assign link.master_dq_oe = 1'b0;
    assign link.cmd_valid = valid_q;
    assign link.cmd_code = code_q;
    assign link.cmd_arg = arg_q;
    assign link.read_slot = slot_q;
    assign link.strong_pullup = spu_q;
    assign busy_out = busy_q;
    assign done_out = done_q;
    assign temp_out = temp_q;
endmodule
`default_nettype wire

// [src/therm_regs.svh]
// Constants for the thermometer conversion block: command codes, field
// positions, reset values and timing counts. Included by bare name.
`ifndef THERM_REGS_SVH
`define THERM_REGS_SVH
`define CMD_CONVERT 8'h44
`define CMD_READ_RESULT 8'hbe
`define CMD_WRITE_CFG 8'h4e
`define RESULT_POR 16'h0550
`define CFG_POR 8'h7f
`define CFG_RES_LSB 5
`define CFG_RES_MSB 6
`define SIGN_LSB 11
`define SIGN_MSB 15
`define CONV_TIME_US 750
`define CLK_MHZ 25
`define CONV_CYCLES (`CONV_TIME_US * `CLK_MHZ)
`endif

// [src/therm_pkg.sv]
// Types used by the device end of the thermometer link.
// Assumes the constants header is compiled alongside.
package therm_pkg;
    typedef enum logic [1:0] {
        RES_9 = 2'h0,
        RES_10 = 2'h1,
        RES_11 = 2'h2,
        RES_12 = 2'h3
    } res_t;
endpackage

// [src/therm_link_if.sv]
// Link between the bus master and the thermometer device.
// The shared data line is open drain: it reads low when either party drives.
`timescale 1ns/1ns
`default_nettype none
interface therm_link_if;
    logic master_dq_oe;
    logic device_dq_oe;
    logic dq_level;
    logic cmd_valid;
    logic [7:0] cmd_code;
    logic [7:0] cmd_arg;
    logic read_slot;
    logic [15:0] result_word;
    logic [7:0] cfg_word;
    logic strong_pullup;
    // Weak pullup holds the line high unless someone pulls low.
    assign dq_level = ~(master_dq_oe | device_dq_oe);
    modport device (
        input dq_level, cmd_valid, cmd_code, cmd_arg, read_slot, strong_pullup,
        output device_dq_oe, result_word, cfg_word
    );
    modport master (
        input dq_level, result_word, cfg_word,
        output master_dq_oe, cmd_valid, cmd_code, cmd_arg, read_slot, strong_pullup
    );
endinterface
`default_nettype wire

// [src/therm_device.sv]
// Device end: conversion control and result formatting of the thermometer.
// Assumes commands arrive already decoded from bus slots and ROM selection.
`timescale 1ns/1ns
`default_nettype none
`include "therm_regs.svh"
module therm_device #(
    parameter int CONV_CYCLES = `CONV_CYCLES,
    parameter logic [63:0] ID_CODE = 64'h0123_4567_89ab_cd5a, // Arbitrary value.
    parameter logic [7:0] TH_POR = 8'h4b,
    parameter logic [7:0] TL_POR = 8'h46
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    therm_link_if.device link,
    input wire logic [11:0] sensor_in,
    input wire logic local_supply_pin_in,
    output logic converting_out,
    output logic [63:0] id_out,
    output logic [7:0] th_out,
    output logic [7:0] tl_out
);
    typedef enum logic [1:0] {D_IDLE, D_CONV, D_STORE} dstate_t;
    dstate_t st_q, st_d;
    logic [31:0] cnt_q, cnt_d;
    logic [15:0] result_q, result_d;
    logic [7:0] cfg_q, cfg_d;
    logic [7:0] th_q, tl_q;
    logic pull_q, pull_d, conv_q, conv_d;
    logic [11:0] sens_s1_q, sens_s2_q;
    logic sup_s1_q, sup_s2_q;
    therm_pkg::res_t res;
    logic [11:0] raw;
    assign res = therm_pkg::res_t'(cfg_q[`CFG_RES_MSB:`CFG_RES_LSB]);
    always_comb begin
        raw = sens_s2_q;
        // Coarser settings clear the undefined low bits.
        case (res)
            therm_pkg::RES_9: raw[2:0] = 3'h0;
            therm_pkg::RES_10: raw[1:0] = 2'h0;
            therm_pkg::RES_11: raw[0] = 1'b0;
            default: raw = sens_s2_q;
        endcase
    end
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        result_d = result_q;
        cfg_d = cfg_q;
        pull_d = 1'b0;
        conv_d = conv_q;
        if (link.cmd_valid && link.cmd_code == `CMD_WRITE_CFG) begin
            cfg_d = link.cmd_arg;
        end
        case (st_q)
            D_IDLE: begin
                conv_d = 1'b0;
                if (link.cmd_valid && link.cmd_code == `CMD_CONVERT) begin
                    st_d = D_CONV;
                    cnt_d = 32'h0;
                    conv_d = 1'b1;
                end
            end
            D_CONV: begin
                // Result stays untouched throughout the conversion.
                cnt_d = cnt_q + 32'h1;
                if (cnt_q >= 32'(CONV_CYCLES - 1)) begin
                    st_d = D_STORE;
                end
            end
            default: begin
                // Sign fills bits 15..11; bits 10..0 weigh 2^6..2^-4.
                result_d = {{4{raw[11]}}, raw};
                conv_d = 1'b0;
                st_d = D_IDLE;
            end
        endcase
        // A busy device answers a read slot by pulling low, only when self-powered.
        if (link.read_slot && conv_q && sup_s2_q && !link.strong_pullup) begin
            pull_d = 1'b1;
        end
    end
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            st_q <= D_IDLE;
            cnt_q <= 32'h0;
            result_q <= `RESULT_POR;
            cfg_q <= `CFG_POR;
            th_q <= TH_POR;
            tl_q <= TL_POR;
            pull_q <= 1'b0;
            conv_q <= 1'b0;
            sens_s1_q <= 12'h0;
            sens_s2_q <= 12'h0;
            sup_s1_q <= 1'b0;
            sup_s2_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            result_q <= result_d;
            cfg_q <= cfg_d;
            th_q <= th_q;
            tl_q <= tl_q;
            pull_q <= pull_d;
            conv_q <= conv_d;
            sens_s1_q <= sensor_in;
            sens_s2_q <= sens_s1_q;
            sup_s1_q <= local_supply_pin_in;
            sup_s2_q <= sup_s1_q;
        end
    end
    assign link.device_dq_oe = pull_q;
    assign link.result_word = result_q;
    assign link.cfg_word = cfg_q;
    assign converting_out = conv_q;
    assign id_out = ID_CODE;
    assign th_out = th_q;
    assign tl_out = tl_q;
endmodule
`default_nettype wire

// [bench/temp_conversion_result_ctrl_chk.sv]
// Concurrent checks on the link between the master and the thermometer.
// Assumes the link signals arrive as plain inputs from the bench top.
`timescale 1ns/1ns
`default_nettype none
`include "therm_regs.svh"
module temp_conversion_result_ctrl_chk #(
    parameter int CONV_CYCLES = 20
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic master_dq_oe,
    input wire logic device_dq_oe,
    input wire logic dq_level,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    input wire logic [7:0] cmd_arg,
    input wire logic read_slot,
    input wire logic [15:0] result_word,
    input wire logic [7:0] cfg_word,
    input wire logic strong_pullup
);
    // ==========================================================
    // Conversion tracker
    int conv_cnt_q;
    int conv_cnt_d;
    always_comb begin
        conv_cnt_d = conv_cnt_q;
        if (sys_rst_in) begin
            conv_cnt_d = 0;
        end else if (conv_cnt_q != 0) begin
            conv_cnt_d = (conv_cnt_q == CONV_CYCLES + 2) ? 0 : conv_cnt_q + 1;
        end else if (cmd_valid && cmd_code == `CMD_CONVERT) begin
            conv_cnt_d = 1;
        end
    end
    always_ff @(posedge clk_in) begin
        conv_cnt_q <= conv_cnt_d;
    end
    // ==========================================================
    // Assertions
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    AST_RESET_VALUES: assert property (disable iff (1'b0) sys_rst_in |=>
        cfg_word == `CFG_POR && result_word == `RESULT_POR) else $error("bad reset values");
    AST_CFG_WRITE: assert property (cmd_valid && cmd_code == `CMD_WRITE_CFG |=>
        cfg_word == $past(cmd_arg)) else $error("config write lost");
    AST_SIGN_FILL: assert property (result_word[15:11] == 5'h00 ||
        result_word[15:11] == 5'h1f) else $error("sign bits not uniform");
    AST_LOW_BITS: assert property ($changed(result_word) |->
        (result_word[2:0] & ~(3'h7 << (2'h3 - cfg_word[6:5]))) == 3'h0)
        else $error("undefined low bits not zero");
    AST_STORE_TIME: assert property ($changed(result_word) |->
        conv_cnt_q == CONV_CYCLES + 2) else $error("result stored at wrong time");
    AST_HOLD_OLD: assert property (conv_cnt_q >= 1 && conv_cnt_q <= CONV_CYCLES |->
        $stable(result_word) [*2]) else $error("result changed mid conversion");
    AST_PULL_ONCE: assert property (device_dq_oe |=> !device_dq_oe)
        else $error("device pull longer than one cycle");
    AST_PULL_CAUSE: assert property (device_dq_oe |-> $past(read_slot) && !dq_level)
        else $error("device pull without read slot");
    AST_NO_PULL_POWERED: assert property (strong_pullup |-> !device_dq_oe)
        else $error("device pulled during strong pullup");
    AST_CMD_PULSE: assert property (cmd_valid |=> !cmd_valid)
        else $error("command strobe too long");
    AST_POLL_BUSY: assert property (read_slot && !strong_pullup && conv_cnt_q >= 2 &&
        conv_cnt_q <= CONV_CYCLES |=> device_dq_oe) else $error("busy device did not answer");
endmodule
`default_nettype wire

// [bench/temp_conversion_result_ctrl_bench.sv]
// Self-checking bench joining both ends of the thermometer link.
// Assumes the design sources and constants header are compiled first.
`timescale 1ns/1ns
`default_nettype none
`include "therm_regs.svh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin miscompares++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (a), (b)); end end
module temp_conversion_result_ctrl_bench;
    localparam int CONV = 20;
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic start_in = 1'b0;
    logic parasite_in = 1'b0;
    logic cfg_wr_in = 1'b0;
    logic [7:0] cfg_in = 8'h00;
    logic [11:0] sensor_in = 12'h000;
    logic supply_in = 1'b1;
    logic busy_out;
    logic done_out;
    logic [15:0] temp_out;
    logic converting_out;
    int checks = 0;
    int miscompares = 0;
    logic [11:0] corner [4] = '{12'h000, 12'hfff, 12'h7ff, 12'h800};
    therm_link_if therm_link_if_inst ();
    therm_master therm_master_inst (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .link(therm_link_if_inst.master), .start_in(start_in), .parasite_in(parasite_in),
        .cfg_wr_in(cfg_wr_in), .cfg_in(cfg_in), .busy_out(busy_out), .done_out(done_out),
        .temp_out(temp_out));
    therm_device #(.CONV_CYCLES(CONV)) therm_device_inst (.clk_in(clk_in),
        .sys_rst_in(sys_rst_in), .link(therm_link_if_inst.device), .sensor_in(sensor_in),
        .local_supply_pin_in(supply_in), .converting_out(converting_out), .id_out(),
        .th_out(), .tl_out());
    temp_conversion_result_ctrl_chk #(.CONV_CYCLES(CONV)) temp_conversion_result_ctrl_chk_inst (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .master_dq_oe(therm_link_if_inst.master_dq_oe),
        .device_dq_oe(therm_link_if_inst.device_dq_oe),
        .dq_level(therm_link_if_inst.dq_level), .cmd_valid(therm_link_if_inst.cmd_valid),
        .cmd_code(therm_link_if_inst.cmd_code), .cmd_arg(therm_link_if_inst.cmd_arg),
        .read_slot(therm_link_if_inst.read_slot),
        .result_word(therm_link_if_inst.result_word),
        .cfg_word(therm_link_if_inst.cfg_word),
        .strong_pullup(therm_link_if_inst.strong_pullup));
    initial begin
        forever #20 clk_in = ~clk_in;
    end
    // Low bits below the chosen resolution are expected as zero.
    function automatic logic [15:0] exp_word(logic [11:0] raw, logic [1:0] res);
        logic [15:0] w;
        w = {{4{raw[11]}}, raw};
        w[2:0] = w[2:0] & (3'h7 << (2'h3 - res));
        return w;
    endfunction
    task automatic give_verdict;
        if (miscompares == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic run(input logic [11:0] raw, input logic [1:0] res, input logic para);
        int n;
        logic [15:0] old;
        parasite_in = para;
        supply_in = ~para;
        sensor_in = raw;
        cfg_in = {1'b0, res, 5'h1f};
        cfg_wr_in = 1'b1;
        @(negedge clk_in);
        cfg_wr_in = 1'b0;
        repeat (8) @(negedge clk_in);
        `CHK(therm_link_if_inst.cfg_word, cfg_in)
        old = therm_link_if_inst.result_word;
        start_in = 1'b1;
        @(negedge clk_in);
        start_in = 1'b0;
        repeat (4) @(negedge clk_in);
        `CHK(converting_out, 1'b1)
        `CHK(busy_out, 1'b1)
        `CHK(therm_link_if_inst.result_word, old)
        n = 0;
        while (done_out !== 1'b1 && n < 20000) begin
            @(negedge clk_in);
            n++;
        end
        `CHK(temp_out, exp_word(raw, res))
        `CHK(therm_link_if_inst.result_word, exp_word(raw, res))
        `CHK(converting_out, 1'b0)
    endtask
    initial begin
        void'($urandom(80218));
        repeat (2) @(negedge clk_in);
        sys_rst_in = 1'b0;
        `CHK(therm_link_if_inst.result_word, `RESULT_POR)
        `CHK(therm_link_if_inst.cfg_word, `CFG_POR)
        for (int r = 0; r < 4; r++) begin
            run(corner[r], 2'(r), 1'b0);
        end
        for (int i = 0; i < 8; i++) begin
            run(12'($urandom), 2'($urandom), 1'b0);
        end
        run(12'($urandom), 2'h3, 1'b1);
        sys_rst_in = 1'b1;
        repeat (2) @(negedge clk_in);
        sys_rst_in = 1'b0;
        `CHK(therm_link_if_inst.cfg_word, `CFG_POR)
        give_verdict();
    end
    // Cut a hang short: the parasite run alone needs about 19000 cycles.
    initial begin
        repeat (40000) @(posedge clk_in);
        miscompares++;
        give_verdict();
    end
endmodule
`default_nettype wire
